// File: core/tpg_cfg.svh
// Constants for the video test pattern generator
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

`define TPG_FIFO_DEPTH 32
`define TPG_FIFO_AW    5

// Timing: h active, hsync start, hsync end, h total, square width,
//         v active, vsync start, vsync end, v total, square height
`define TPG_T480   {12'h2D0, 12'h2E0, 12'h31E, 12'h35A, 12'h05A, \
                    12'h1E0, 12'h1E9, 12'h1EF, 12'h20D, 12'h050}
`define TPG_T576   {12'h2D0, 12'h2DC, 12'h31C, 12'h360, 12'h05A, \
                    12'h240, 12'h245, 12'h24A, 12'h271, 12'h060}
`define TPG_T720_60 {12'h500, 12'h56E, 12'h596, 12'h672, 12'h0A0, \
                    12'h2D0, 12'h2D5, 12'h2DA, 12'h2EE, 12'h078}
`define TPG_T720_50 {12'h500, 12'h6B8, 12'h6E0, 12'h7BC, 12'h0A0, \
                    12'h2D0, 12'h2D5, 12'h2DA, 12'h2EE, 12'h078}
`define TPG_T1080_60 {12'h780, 12'h7D8, 12'h804, 12'h898, 12'h0F0, \
                    12'h438, 12'h43C, 12'h441, 12'h465, 12'h0B4}
`define TPG_T1080_50 {12'h780, 12'h990, 12'h9BC, 12'hA50, 12'h0F0, \
                    12'h438, 12'h43C, 12'h441, 12'h465, 12'h0B4}

`define TPG_RGB_RED   24'hFF0000
`define TPG_RGB_GREEN 24'h00FF00
`define TPG_RGB_BLUE  24'h0000FF
`define TPG_RGB_BLACK 24'h000000
`define TPG_RGB_WHITE 24'hFFFFFF
`define TPG_ONE12     12'h001
`define TPG_ONE3      3'h1

`endif

// File: core/tpg_pkg.sv
// Types shared by the video test pattern generator
package tpg_pkg;
    typedef enum logic [2:0] {
        TPG_PAT_RED = 3'h0, TPG_PAT_GREEN = 3'h1, TPG_PAT_BLUE = 3'h2, TPG_PAT_BLACK = 3'h3,
        TPG_PAT_WHITE = 3'h4, TPG_PAT_RAMP = 3'h5, TPG_PAT_CHESS = 3'h6, TPG_PAT_BARS = 3'h7
    } tpg_pat_t;
    typedef enum logic [2:0] {
        TPG_RES_480 = 3'h0, TPG_RES_576 = 3'h1, TPG_RES_720_60 = 3'h2,
        TPG_RES_720_50 = 3'h3, TPG_RES_1080_50 = 3'h4, TPG_RES_1080_60 = 3'h5
    } tpg_res_t;
    typedef enum logic [1:0] {
        TPG_SRC_XTAL = 2'h0, TPG_SRC_AVCO = 2'h1, TPG_SRC_MAIN = 2'h2, TPG_SRC_ROVE = 2'h3
    } tpg_src_t;
    typedef enum logic [0:0] {
        TPG_ST_IDLE = 1'h0, TPG_ST_RUN = 1'h1
    } tpg_state_t;
    typedef struct packed {
        tpg_pat_t pat;
        tpg_res_t res;
        tpg_src_t src;
    } tpg_cfg_t;
    typedef struct packed {
        logic [11:0] ha, hss, hse, ht, cw, va, vss, vse, vt, ch;
    } tpg_timing_t;
    typedef struct packed {
        logic        aud_valid;
        logic [23:0] aud;
        logic [23:0] rgb;
        logic        hs;
        logic        vs;
        logic        de;
    } tpg_pix_t;
endpackage

// File: core/tpg_top.sv
// Video test pattern generator with pixel FIFO and transmitter output mux
`timescale 1ns/1ps
`default_nettype none
`include "tpg_cfg.svh"
// Pixel buffer between pattern generator and output mux
module tpg_fifo #(
    parameter int W = 52,
    parameter int D = `TPG_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next;
    logic         full, empty;
    // Extra pointer bit tells full from empty
    assign empty     = (wp_reg == rp_reg);
    assign full      = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp_reg[AW-1:0]];
    // Pointer advance; the step is built at pointer width
    always_comb begin
        wp_next = wp_reg + {{AW{1'b0}}, in_valid && !full};
        rp_next = rp_reg + {{AW{1'b0}}, out_ready && !empty};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end
    // Storage has no reset; words are only read once written
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wp_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

module tpg_top
    import tpg_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic        CLK_XTAL,
    input  wire logic        CLK_AVCO,
    input  wire logic        CLK_MAIN,
    input  wire logic        CLK_ROVE,
    input  wire logic        XTAL_IS_27M,
    input  wire logic        TPG_EN,
    input  wire logic [2:0]  PAT_SEL,
    input  wire logic [2:0]  RES_SEL,
    input  wire logic [1:0]  SRC_SEL,
    input  wire logic        OUT_SEL,
    input  wire tpg_pix_t    MAIN_DATA,
    input  wire logic        MAIN_VALID,
    output logic             MAIN_READY,
    input  wire logic [23:0] AUD_DATA,
    input  wire logic        AUD_VALID,
    output logic             AUD_READY,
    output tpg_pix_t         TX_DATA,
    output logic             TX_VALID,
    input  wire logic        TX_READY,
    output logic             TPG_ACTIVE,
    output tpg_cfg_t         ACT_CFG,
    output logic             PCLK_RATE_OK,
    output logic             AUD_EXTRACT_OFF
);
    tpg_state_t  state_reg, state_next;
    tpg_cfg_t    cfg_reg, cfg_next, cfg_in;
    tpg_timing_t tim;
    logic [11:0] h_reg, h_next, v_reg, v_next, cx_reg, cx_next, cy_reg, cy_next;
    logic [2:0]  col_reg, col_next, row_reg, row_next;
    logic [3:0]  s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next, rise;
    logic        aud_held_reg, aud_held_next, aud_in;
    logic [23:0] aud_reg, aud_next;
    logic        rate_ok_reg, rate_ok_next;
    logic        pix_tick, wr_valid, wr_ready, wr_fire, h_wrap, frame_wrap;
    tpg_pix_t    wr_word, fifo_word, tx_reg, tx_next, src_word;
    logic        fifo_valid, fifo_ready, tx_valid_reg, tx_valid_next, load, src_valid;
    // Timing set for one resolution code; unknown codes fall back to 480p
    function automatic tpg_timing_t timing_of(input tpg_res_t r);
        unique case (r)
            TPG_RES_576:     timing_of = `TPG_T576;
            TPG_RES_720_60:  timing_of = `TPG_T720_60;
            TPG_RES_720_50:  timing_of = `TPG_T720_50;
            TPG_RES_1080_50: timing_of = `TPG_T1080_50;
            TPG_RES_1080_60: timing_of = `TPG_T1080_60;
            default:         timing_of = `TPG_T480;
        endcase
    endfunction
    // Whether a source can deliver the rate a resolution needs
    function automatic logic rate_fits(input tpg_res_t r, input tpg_src_t s, input logic x27);
        if (s == TPG_SRC_MAIN || s == TPG_SRC_ROVE) begin
            rate_fits = 1'b1;
        end else if (r == TPG_RES_480 || r == TPG_RES_576) begin
            rate_fits = (s == TPG_SRC_XTAL) && x27;
        end else if (r == TPG_RES_720_60 || r == TPG_RES_720_50) begin
            rate_fits = (s == TPG_SRC_AVCO) && x27;
        end else begin
            rate_fits = 1'b0;
        end
    endfunction
    // Colour of the current pixel
    function automatic logic [23:0] color_of(input tpg_pat_t p, input logic [11:0] h,
                                             input logic [2:0] col, input logic [2:0] row);
        unique case (p)
            TPG_PAT_RED:   color_of = `TPG_RGB_RED;
            TPG_PAT_GREEN: color_of = `TPG_RGB_GREEN;
            TPG_PAT_BLUE:  color_of = `TPG_RGB_BLUE;
            TPG_PAT_BLACK: color_of = `TPG_RGB_BLACK;
            TPG_PAT_WHITE: color_of = `TPG_RGB_WHITE;
            TPG_PAT_RAMP:  color_of = {3{h[7:0]}};
            TPG_PAT_CHESS: color_of = (col[0] ^ row[0]) ? `TPG_RGB_WHITE : `TPG_RGB_BLACK;
            TPG_PAT_BARS:  color_of = {{8{~col[1]}}, {8{~col[2]}}, {8{~col[0]}}};
        endcase
    endfunction
    assign cfg_in = '{pat: tpg_pat_t'(PAT_SEL), res: tpg_res_t'(RES_SEL),
                      src: tpg_src_t'(SRC_SEL)};
    assign tim = timing_of(cfg_reg.res);
    // Source edge accepted once second and third stages agree
    assign rise     = s2_reg & s3_reg & ~lvl_reg;
    assign pix_tick = rise[cfg_reg.src];
    assign h_wrap     = (h_reg == tim.ht - `TPG_ONE12);
    assign frame_wrap = h_wrap && (v_reg == tim.vt - `TPG_ONE12);
    // Generator stalls whenever the FIFO is full; that source edge is skipped
    assign wr_valid = (state_reg == TPG_ST_RUN) && pix_tick;
    assign wr_fire  = wr_valid && wr_ready;
    assign aud_in   = AUD_VALID && AUD_READY;
    assign AUD_READY = !aud_held_reg;
    // Pattern word, audio sample rides on the next pixel written
    always_comb begin
        wr_word.de  = (h_reg < tim.ha) && (v_reg < tim.va);
        wr_word.hs  = (h_reg >= tim.hss) && (h_reg < tim.hse);
        wr_word.vs  = (v_reg >= tim.vss) && (v_reg < tim.vse);
        wr_word.rgb = wr_word.de ? color_of(cfg_reg.pat, h_reg, col_reg, row_reg)
                                 : `TPG_RGB_BLACK;
        wr_word.aud_valid = aud_held_reg;
        wr_word.aud       = aud_reg;
    end
    // Generator next state
    always_comb begin
        state_next = state_reg;
        cfg_next   = cfg_reg;
        h_next     = h_reg;
        v_next     = v_reg;
        cx_next    = cx_reg;
        cy_next    = cy_reg;
        col_next   = col_reg;
        row_next   = row_reg;
        lvl_next   = lvl_reg;
        for (int i = 0; i < 4; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
        // Audio flag: a new sample wins over the one being consumed
        aud_held_next = aud_held_reg;
        aud_next      = aud_reg;
        if (wr_fire) begin
            aud_held_next = 1'b0;
        end
        if (aud_in) begin
            aud_held_next = 1'b1;
            aud_next      = AUD_DATA;
        end
        unique case (state_reg)
            TPG_ST_IDLE: begin
                if (TPG_EN) begin
                    state_next = TPG_ST_RUN; // Counters already zero from reset or frame end
                    cfg_next   = cfg_in;
                end
            end
            TPG_ST_RUN: begin
                if (wr_fire) begin
                    if (h_wrap) begin
                        h_next   = '0;
                        cx_next  = '0;
                        col_next = '0;
                        if (frame_wrap) begin
                            // New settings only at the frame edge, never mid frame
                            v_next   = '0;
                            cy_next  = '0;
                            row_next = '0;
                            cfg_next = cfg_in;
                            if (!TPG_EN) begin
                                state_next = TPG_ST_IDLE;
                            end
                        end else begin
                            v_next = v_reg + `TPG_ONE12;
                            if (cy_reg == tim.ch - `TPG_ONE12) begin
                                cy_next  = '0;
                                row_next = row_reg + `TPG_ONE3;
                            end else begin
                                cy_next = cy_reg + `TPG_ONE12;
                            end
                        end
                    end else begin
                        h_next = h_reg + `TPG_ONE12;
                        if (cx_reg == tim.cw - `TPG_ONE12) begin
                            cx_next  = '0;
                            col_next = col_reg + `TPG_ONE3;
                        end else begin
                            cx_next = cx_reg + `TPG_ONE12;
                        end
                    end
                end
            end
        endcase
    end
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg    <= TPG_ST_IDLE;
            cfg_reg      <= '0;
            h_reg        <= '0;
            v_reg        <= '0;
            cx_reg       <= '0;
            cy_reg       <= '0;
            col_reg      <= '0;
            row_reg      <= '0;
            s1_reg       <= '0;
            s2_reg       <= '0;
            s3_reg       <= '0;
            lvl_reg      <= '0;
            aud_held_reg <= 1'b0;
            aud_reg      <= '0;
        end else begin
            state_reg    <= state_next;
            cfg_reg      <= cfg_next;
            h_reg        <= h_next;
            v_reg        <= v_next;
            cx_reg       <= cx_next;
            cy_reg       <= cy_next;
            col_reg      <= col_next;
            row_reg      <= row_next;
            s1_reg       <= {CLK_ROVE, CLK_MAIN, CLK_AVCO, CLK_XTAL};
            s2_reg       <= s1_reg;
            s3_reg       <= s2_reg;
            lvl_reg      <= lvl_next;
            aud_held_reg <= aud_held_next;
            aud_reg      <= aud_next;
        end
    end
    tpg_fifo #(
        .W ($bits(tpg_pix_t)),
        .D (`TPG_FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (RESETN),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_word)
    );
    // Output mux: main pipe or pattern, one registered stage toward the transmitter
    assign load       = !tx_valid_reg || TX_READY;
    assign src_valid  = OUT_SEL ? fifo_valid : MAIN_VALID;
    assign src_word   = OUT_SEL ? fifo_word : MAIN_DATA;
    assign fifo_ready = load && OUT_SEL;
    assign MAIN_READY = load && !OUT_SEL;
    always_comb begin
        tx_valid_next = tx_valid_reg;
        tx_next       = tx_reg;
        if (load) begin
            tx_valid_next = src_valid;
            tx_next       = src_valid ? src_word : tx_reg;
        end
        rate_ok_next = rate_fits(cfg_reg.res, cfg_reg.src, XTAL_IS_27M);
    end
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_valid_reg <= 1'b0;
            tx_reg       <= '0;
            rate_ok_reg  <= 1'b0;
        end else begin
            tx_valid_reg <= tx_valid_next;
            tx_reg       <= tx_next;
            rate_ok_reg  <= rate_ok_next;
        end
    end
    assign TX_VALID     = tx_valid_reg;
    assign TX_DATA      = tx_reg;
    assign TPG_ACTIVE   = (state_reg == TPG_ST_RUN);
    assign ACT_CFG      = cfg_reg;
    assign PCLK_RATE_OK = rate_ok_reg;
    // Shared VCO: extraction must stay off while it clocks the pattern
    assign AUD_EXTRACT_OFF = TPG_ACTIVE && (cfg_reg.src == TPG_SRC_AVCO);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    sequence aud_take_s;
        aud_in && !wr_fire;
    endsequence
    sequence aud_carry_s;
        aud_held_reg [*1] ##0 (wr_fire && wr_word.aud_valid && !aud_in);
    endsequence
    red_pixel_a: assert property (
        (wr_fire && wr_word.de && cfg_reg.pat == TPG_PAT_RED) |-> wr_word.rgb == `TPG_RGB_RED)
        else $error("red pattern pixel has wrong colour");
    line_bound_a: assert property (
        (state_reg == TPG_ST_RUN) |-> (h_reg < tim.ht) && (v_reg < tim.vt))
        else $error("pixel counters beyond frame total");
    tick_source_a: assert property (
        pix_tick |-> s3_reg[cfg_reg.src] ##1 lvl_reg[$past(cfg_reg.src)])
        else $error("pixel tick not tied to one source edge");
    rate_table_a: assert property (
        ##1 ($past(cfg_reg.res) inside {TPG_RES_1080_50, TPG_RES_1080_60} &&
        $past(cfg_reg.src) inside {TPG_SRC_XTAL, TPG_SRC_AVCO}) |-> !PCLK_RATE_OK)
        else $error("1080p rate claimed from crystal or VCO source");
    xtal_rate_a: assert property (
        (!XTAL_IS_27M && cfg_reg.src inside {TPG_SRC_XTAL, TPG_SRC_AVCO}) |=> !PCLK_RATE_OK)
        else $error("rate claimed ok without 27 MHz crystal");
    aud_carry_a: assert property (
        aud_take_s |=> aud_held_reg && wr_word.aud == $past(AUD_DATA))
        else $error("inserted audio sample not held for the stream");
    aud_clear_a: assert property (
        aud_carry_s |=> !aud_held_reg)
        else $error("audio sample not released after tagging a pixel");
    mux_main_a: assert property (
        (load && !OUT_SEL && MAIN_VALID) |=> TX_VALID && TX_DATA == $past(MAIN_DATA))
        else $error("main pipe word not forwarded");
    cfg_frame_a: assert property (
        (state_reg == TPG_ST_RUN && !(wr_fire && frame_wrap)) |=> $stable(cfg_reg))
        else $error("configuration changed inside a frame");
endmodule
`default_nettype wire

// File: tb/tpg_bench.sv
// Self-checking bench for the test pattern generator
`timescale 1ns/1ps
`default_nettype none
module tpg_bench;
    import tpg_pkg::*;
    logic        ref_clk = 1'b0, rst_n = 1'b0, stall = 1'b0;
    logic        clk_xtal = 1'b0, clk_avco = 1'b0, clk_main = 1'b0, clk_rove = 1'b0;
    logic        xtal_27m = 1'b0, tpg_en = 1'b0, out_sel = 1'b0;
    logic [2:0]  pat_sel = 3'h0, res_sel = 3'h0;
    logic [1:0]  src_sel = 2'h0;
    tpg_pix_t    main_data = '0, tx_data;
    logic        main_valid = 1'b0, main_ready, aud_valid = 1'b0, aud_ready;
    logic [23:0] aud_data = 24'h000000;
    logic        tx_valid, tx_ready, tpg_active, rate_ok, aud_off;
    tpg_cfg_t    act_cfg;
    int          err_total = 0, comparisons = 0;
    // Per-case resolution, source, crystal flag and expected rate verdict
    localparam logic [2:0]  RES_T [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h5};
    localparam logic [1:0]  SRC_T [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h3, 2'h0};
    localparam logic [7:0]  X27 = 8'hA5;
    localparam logic [7:0]  OK_T = 8'h55;
    localparam logic [23:0] RGB_T [8] = '{24'hFF0000, 24'h00FF00, 24'h0000FF, 24'h000000,
                                         24'hFFFFFF, 24'h000000, 24'h000000, 24'hFFFFFF};
    // Slow pixel sources so 125 MHz sampling never aliases
    always #4 ref_clk = ~ref_clk;
    always #40 clk_xtal = ~clk_xtal;
    always #44 clk_avco = ~clk_avco;
    always #48 clk_main = ~clk_main;
    always #52 clk_rove = ~clk_rove;

    tpg_top uut (.REF_CLK(ref_clk), .RESETN(rst_n), .CLK_XTAL(clk_xtal), .CLK_AVCO(clk_avco),
        .CLK_MAIN(clk_main), .CLK_ROVE(clk_rove), .XTAL_IS_27M(xtal_27m), .TPG_EN(tpg_en),
        .PAT_SEL(pat_sel), .RES_SEL(res_sel), .SRC_SEL(src_sel), .OUT_SEL(out_sel),
        .MAIN_DATA(main_data), .MAIN_VALID(main_valid), .MAIN_READY(main_ready),
        .AUD_DATA(aud_data), .AUD_VALID(aud_valid), .AUD_READY(aud_ready),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .TPG_ACTIVE(tpg_active), .ACT_CFG(act_cfg), .PCLK_RATE_OK(rate_ok),
        .AUD_EXTRACT_OFF(aud_off));
    tpg_sink snk (.clk(ref_clk), .rst_n(rst_n), .stall(stall), .valid(tx_valid),
        .data(tx_data), .ready(tx_ready));

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [51:0] got, input logic [51:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset clears the captured words so each case starts clean
    task automatic do_reset();
        rst_n = 1'b0;
        tpg_en = 1'b0;
        xtal_27m = 1'b0;
        step(10);
        snk.q.delete();
        rst_n = 1'b1;
        step(1);
    endtask

    task automatic read_word(output tpg_pix_t w);
        int n = 0;
        while (snk.q.size() == 0 && n < 5000) begin
            step(1);
            n++;
        end
        w = '0;
        if (snk.q.size() == 0) begin
            check(52'h0, 52'h1);
        end else begin
            w = snk.q.pop_front();
        end
    endtask

    // Valid stays up on exit so back-to-back calls never re-raise it
    task automatic send_main(input tpg_pix_t w);
        main_data = w;
        main_valid = 1'b1;
        for (int n = 0; n < 100 && main_ready !== 1'b1; n++) step(1);
        step(1);
    endtask

    task automatic send_aud(input logic [23:0] s);
        aud_data = s;
        aud_valid = 1'b1;
        for (int n = 0; n < 100 && aud_ready !== 1'b1; n++) step(1);
        step(1);
        aud_valid = 1'b0;
        check({51'h0, aud_ready}, 52'h0);
    endtask

    initial begin
        #500000;
        err_total++;
        results();
    end

    initial begin
        tpg_pix_t    w;
        logic [23:0] e;
        logic [7:0]  cfg;
        do_reset();
        send_main(52'hA_BCDE_F012_3457);
        send_main(52'h1_2345_6789_ABCD);
        main_valid = 1'b0;
        check({51'h0, main_ready}, 52'h1);
        read_word(w);
        check(w, 52'hA_BCDE_F012_3457);
        read_word(w);
        check(w, 52'h1_2345_6789_ABCD);
        // One case per pattern code, timing and source taken from RES_T and SRC_T, some repeated
        for (int i = 0; i < 8; i++) begin
            do_reset();
            check({40'h0, tpg_active, tx_valid, rate_ok, aud_ready, act_cfg}, 52'h100);
            cfg = {i[2:0], RES_T[i], SRC_T[i]};
            pat_sel = i[2:0];
            res_sel = RES_T[i];
            src_sel = SRC_T[i];
            xtal_27m = X27[i];
            out_sel = 1'b1;
            stall = (i == 5);
            if (i == 0) send_aud(24'h5A3C96);
            tpg_en = 1'b1;
            step(1);
            check({51'h0, tpg_active}, 52'h1);
            check({44'h0, act_cfg}, {44'h0, cfg});
            pat_sel = ~i[2:0];
            step(2);
            check({44'h0, act_cfg}, {44'h0, cfg});
            check({51'h0, rate_ok}, {51'h0, OK_T[i]});
            check({51'h0, aud_off}, {51'h0, SRC_T[i] == 2'h1});
            check({51'h0, main_ready}, 52'h0);
            // Stalled sink fills the buffer; no ramp step may be lost
            if (i == 5) begin
                step(600);
                stall = 1'b0;
            end
            for (int k = 0; k < ((i == 5) ? 64 : 1); k++) begin
                read_word(w);
                e = (i == 5) ? {3{k[7:0]}} : RGB_T[i];
                check({28'h0, w.rgb}, {28'h0, e});
                check({49'h0, w.hs, w.vs, w.de}, 52'h1);
            end
            if (i == 0) begin
                check({27'h0, w.aud_valid, w.aud}, {27'h0, 1'b1, 24'h5A3C96});
                step(2);
                check({51'h0, aud_ready}, 52'h1);
            end
            tpg_en = 1'b0;
        end
        results();
    end
endmodule
`default_nettype wire

// File: tb/tpg_sink.sv
// Transmitter-side sink model: accepts pixel words and queues them
`timescale 1ns/1ps
`default_nettype none
module tpg_sink
    import tpg_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire logic     stall,
    input  wire logic     valid,
    input  wire tpg_pix_t data,
    output logic          ready
);
    tpg_pix_t q[$];
    // Stalling drops ready so the pixel buffer must absorb the stream
    assign ready = rst_n && !stall;
    // Words kept in arrival order for the bench to compare
    always @(posedge clk) begin
        if (rst_n && valid && ready) begin
            q.push_back(data);
        end
    end
endmodule
`default_nettype wire
